//--- core/ext_bus_pkg.sv
/*
  Constants and carriers for the external bus access sequencer.
  Assumes one zone timing set is presented at a time by the core.
*/
package ext_bus_pkg;
  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int LEAD_W = 2;
  localparam int ACTIVE_W = 3;
  localparam int TRAIL_W = 2;
  localparam int ADDR_W = 19;
  localparam int CNT_W = 5;
  localparam int SYNC_STAGES = 3;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [LEAD_W-1:0] read_lead_count;
    logic [ACTIVE_W-1:0] read_active_count;
    logic [TRAIL_W-1:0] read_trail_count;
    logic [LEAD_W-1:0] write_lead_count;
    logic [ACTIVE_W-1:0] write_active_count;
    logic [TRAIL_W-1:0] write_trail_count;
    logic period_doubling;
    logic ready_sampling_enable;
    logic ready_style_select;
  } zone_timing_config_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] address;
  } access_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALIGN,
    ST_LEAD,
    ST_ACTIVE,
    ST_TRAIL
  } access_state_t;
endpackage : ext_bus_pkg

//--- core/external_bus_access_timing.sv
/*
  External parallel memory access sequencer: lead, active and trail
  phases counted in interface timing clock cycles, aligned to an
  optional half-rate external bus clock.
  Assumes clk is the core system clock and that the core holds a
  request and its zone settings steady until access_done.
*/
// What this block does
// - No check of programmed zone timing values.
// - Timing clock full/half rate; bus clock same/half.
// - Phases counted and strobes moved on timing edges.
// - Same-rate bus clock: changes on its rising edge.
// - Half-rate bus clock: edge follows cycle parity.
// - Access starts on rising bus edge; align cycle.
// - Strobe asserts at active start.
// - Strobe releases at trail start.
// - Zone select and direction release at end.
// - Address held between accesses and alignment cycles.
// - Alignment cycle drives all controls inactive.
// - Ready ignored when sampling disabled.
// - Lead/trail doubled; active count doubled plus waits plus one.
// - Wait term counts ready-inserted cycles only.
// - Sampling enable chooses ready mode; style select is unused.
// - Ready first sampled after lead plus active; resampled.
`timescale 1ns/100ps
module external_bus_access_timing (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timing_half_rate,
  input wire logic bus_half_rate,
  input wire ext_bus_pkg::zone_timing_config_t zone_timing_config,
  input wire logic access_request,
  input wire ext_bus_pkg::access_cmd_t access_cmd,
  input wire logic external_ready_in,
  output logic access_done,
  output logic busy,
  output logic interface_timing_clock,
  output logic external_bus_clock,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic zone_select_n,
  output logic direction_line,
  output logic [ext_bus_pkg::ADDR_W-1:0] external_address_bus
);
  // ----------------------------------------------------------------
  // Timing clock and bus clock phases
  // ----------------------------------------------------------------
  logic tim_phase;
  logic bus_phase;
  wire tim_tick = !timing_half_rate || tim_phase;
  wire bus_rise_next = !bus_half_rate || !bus_phase;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tim_phase <= 1'b0;
      bus_phase <= 1'b0;
    end else begin
      tim_phase <= timing_half_rate ? !tim_phase : 1'b0;
      if (tim_tick) begin
        bus_phase <= bus_half_rate ? !bus_phase : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready pin synchroniser
  // ----------------------------------------------------------------
  // A pin change counts only once the second and third stages agree.
  logic ready_sync [ext_bus_pkg::SYNC_STAGES];
  logic ready_level;
  wire ready_agree = ready_sync[1] == ready_sync[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_sync[0] <= 1'b0;
    end else begin
      ready_sync[0] <= external_ready_in;
    end
  end

  for (genvar i = 1; i < ext_bus_pkg::SYNC_STAGES; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ready_sync[i] <= 1'b0;
      end else begin
        ready_sync[i] <= ready_sync[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_level <= 1'b0;
    end else if (ready_agree) begin
      ready_level <= ready_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------
  // Settings are used as programmed; an illegal mix is simply run.
  ext_bus_pkg::access_cmd_t cmd;
  ext_bus_pkg::access_state_t state;
  ext_bus_pkg::access_state_t next_state;
  logic [ext_bus_pkg::CNT_W-1:0] cnt;
  logic [ext_bus_pkg::CNT_W-1:0] next_cnt;

  wire dbl = zone_timing_config.period_doubling;
  wire [ext_bus_pkg::LEAD_W-1:0] lead_sel = cmd.write ?
    zone_timing_config.write_lead_count :
    zone_timing_config.read_lead_count;
  wire [ext_bus_pkg::ACTIVE_W-1:0] active_sel = cmd.write ?
    zone_timing_config.write_active_count :
    zone_timing_config.read_active_count;
  wire [ext_bus_pkg::TRAIL_W-1:0] trail_sel = cmd.write ?
    zone_timing_config.write_trail_count :
    zone_timing_config.read_trail_count;

  function automatic logic [ext_bus_pkg::CNT_W-1:0] scaled(
    input logic [3:0] count,
    input logic doubling
  );
    scaled = doubling ? {count, 1'b0} : {1'b0, count};
  endfunction : scaled

  wire [ext_bus_pkg::CNT_W-1:0] lead_len =
    scaled({2'h0, lead_sel}, dbl);
  wire [ext_bus_pkg::CNT_W-1:0] active_len =
    ext_bus_pkg::CNT_W'(scaled({1'h0, active_sel}, dbl)
    + ext_bus_pkg::CNT_ONE);
  wire [ext_bus_pkg::CNT_W-1:0] trail_len =
    scaled({2'h0, trail_sel}, dbl);

  // Waiting is only possible in sampling mode; either ready style
  // reads the same filtered level, so async mode needs no extra path.
  wire use_ready = zone_timing_config.ready_sampling_enable;
  wire hold_wait = use_ready && !ready_level;
  wire last_cycle = cnt == ext_bus_pkg::CNT_ONE;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every step after ST_IDLE waits for a timing tick, so phase lengths and the
  // parity of each strobe edge against the bus clock follow from the
  // programmed counts and any ready waits, with no separate parity tracking.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ext_bus_pkg::ST_IDLE: begin
        if (access_request) begin
          next_state = ext_bus_pkg::ST_ALIGN;
        end
      end
      ext_bus_pkg::ST_ALIGN: begin
        if (tim_tick && bus_rise_next) begin
          if (lead_len != ext_bus_pkg::CNT_ZERO) begin
            next_state = ext_bus_pkg::ST_LEAD;
            next_cnt = lead_len;
          end else begin
            next_state = ext_bus_pkg::ST_ACTIVE;
            next_cnt = active_len;
          end
        end
      end
      ext_bus_pkg::ST_LEAD: begin
        if (tim_tick) begin
          next_cnt = ext_bus_pkg::CNT_W'(cnt - ext_bus_pkg::CNT_ONE);
          if (last_cycle) begin
            next_state = ext_bus_pkg::ST_ACTIVE;
            next_cnt = active_len;
          end
        end
      end
      ext_bus_pkg::ST_ACTIVE: begin
        if (tim_tick) begin
          next_cnt = ext_bus_pkg::CNT_W'(cnt - ext_bus_pkg::CNT_ONE);
          if (last_cycle) begin
            if (hold_wait) begin
              next_cnt = cnt;
            end else if (trail_len != ext_bus_pkg::CNT_ZERO) begin
              next_state = ext_bus_pkg::ST_TRAIL;
              next_cnt = trail_len;
            end else begin
              next_state = ext_bus_pkg::ST_IDLE;
            end
          end
        end
      end
      ext_bus_pkg::ST_TRAIL: begin
        if (tim_tick) begin
          next_cnt = ext_bus_pkg::CNT_W'(cnt - ext_bus_pkg::CNT_ONE);
          if (last_cycle) begin
            next_state = ext_bus_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ext_bus_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next pin levels
  // ----------------------------------------------------------------
  function automatic logic on_bus(input ext_bus_pkg::access_state_t s);
    on_bus = s == ext_bus_pkg::ST_LEAD || s == ext_bus_pkg::ST_ACTIVE ||
      s == ext_bus_pkg::ST_TRAIL;
  endfunction : on_bus

  wire in_access = on_bus(next_state);
  wire strobe_on = next_state == ext_bus_pkg::ST_ACTIVE;
  wire finishing = on_bus(state) &&
    next_state == ext_bus_pkg::ST_IDLE;
  wire starting = state == ext_bus_pkg::ST_ALIGN &&
    next_state != ext_bus_pkg::ST_ALIGN;
  // Half-rate timing clock rises at each tick; half-rate bus clock rises at alternate ticks only.
  // At full rate the timing clock pin can only stand high.
  wire next_tim_clk = timing_half_rate ? tim_phase : 1'b1;
  wire next_bus_clk = bus_half_rate ?
    (tim_tick ? !bus_phase : bus_phase) : next_tim_clk;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ext_bus_pkg::ST_IDLE;
      cnt <= ext_bus_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  // Requests seen while busy are ignored; the command is taken once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (state == ext_bus_pkg::ST_IDLE && access_request) begin
      cmd <= access_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Registered clocks
  // ----------------------------------------------------------------
  // Registering the clocks keeps them in step with the registered
  // strobes, at the cost of one cycle of latency on both.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interface_timing_clock <= 1'b0;
      external_bus_clock <= 1'b0;
    end else begin
      interface_timing_clock <= next_tim_clk;
      external_bus_clock <= next_bus_clk;
    end
  end

  // ----------------------------------------------------------------
  // Registered controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_select_n <= 1'b1;
      direction_line <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      zone_select_n <= !in_access;
      direction_line <= !(in_access && cmd.write);
      read_strobe_n <= !(strobe_on && !cmd.write);
      write_strobe_n <= !(strobe_on && cmd.write);
    end
  end

  // ----------------------------------------------------------------
  // Address and status
  // ----------------------------------------------------------------
  // The address only moves at an access start and never floats.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_address_bus <= ext_bus_pkg::ADDR_RESET;
    end else if (starting) begin
      external_address_bus <= cmd.address;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      access_done <= 1'b0;
      busy <= 1'b0;
    end else begin
      access_done <= finishing;
      busy <= next_state != ext_bus_pkg::ST_IDLE;
    end
  end
endmodule : external_bus_access_timing

//--- test/external_bus_access_timing_asserts.sv
/*
  Concurrent checks on the access sequencer pins.
  Assumes it is bound into every instance of the sequencer.
*/
`timescale 1ns/100ps
module external_bus_access_timing_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timing_half_rate,
  input wire logic busy,
  input wire logic access_done,
  input wire logic external_bus_clock,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic zone_select_n,
  input wire logic direction_line,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] external_address_bus
);
  logic [7:0] zone_low;
  // A counter, because a zone run outlasts any repetition count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_low <= 8'h00;
    end else begin
      zone_low <= zone_select_n ? 8'h00 : zone_low + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_finish;
    access_done && !busy ##1 !access_done;
  endsequence
  property p_in_zone;
    !(read_strobe_n && write_strobe_n) |-> !zone_select_n; endproperty
  property p_wr_dir;
    !write_strobe_n |-> !direction_line; endproperty
  property p_hold;
    zone_select_n && $past(zone_select_n) |-> $stable(external_address_bus);
  endproperty
  property p_align;
    $rose(busy) |-> zone_select_n && write_strobe_n; endproperty
  property p_start;
    $fell(zone_select_n) && timing_half_rate |-> $rose(external_bus_clock);
  endproperty
  property p_end;
    $rose(zone_select_n) |-> s_finish; endproperty
  property p_done;
    $rose(access_done) |-> $rose(zone_select_n); endproperty
  property p_even;
    timing_half_rate && $rose(zone_select_n) |-> !zone_low[0]; endproperty
  a_in_zone: assert property (p_in_zone) else $error("stray strobe");
  a_wr_dir: assert property (p_wr_dir) else $error("write dir");
  a_hold: assert property (p_hold) else $error("address moved");
  a_align: assert property (p_align) else $error("align active");
  a_start: assert property (p_start) else $error("start edge");
  a_end: assert property (p_end) else $error("end pulse");
  a_done: assert property (p_done) else $error("done cause");
  a_even: assert property (p_even) else $error("odd zone run");
endmodule : external_bus_access_timing_asserts

bind external_bus_access_timing external_bus_access_timing_asserts chk (
  .clk, .rst_n, .timing_half_rate, .busy, .access_done, .external_bus_clock,
  .read_strobe_n, .write_strobe_n, .zone_select_n, .direction_line,
  .external_address_bus
);

//--- test/ext_memory_model.sv
/*
  Slow memory on the zoned bus: holds ready low for a set count.
  Assumes the bench chooses the count of its own 800 ns ticks.
*/
`timescale 1ns/100ps
module ext_memory_model (
  input wire logic zone_select_n,
  input wire logic [3:0] wait_ticks,
  output logic ready
);
  logic mclk = 1'b0;
  logic [3:0] cnt = 4'h0;
  always #400 mclk = ~mclk;
  // The ready line is pulled up, so it reads high while deselected.
  assign ready = zone_select_n | (cnt >= wait_ticks);
  always @(posedge mclk or posedge zone_select_n) begin
    if (zone_select_n) begin
      cnt <= 4'h0;
    end else if (cnt < wait_ticks) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ext_memory_model

//--- test/test_external_bus_access_timing.sv
/*
  Self-checking bench for the access sequencer.
  Assumes the checker binds itself and the memory model drives ready.
*/
`timescale 1ns/100ps
module test_external_bus_access_timing;
  logic clk = 1'b0, rst_n = 1'b0, access_request = 1'b0;
  logic timing_half_rate = 1'b0, bus_half_rate = 1'b0;
  ext_bus_pkg::zone_timing_config_t zone_timing_config = '0;
  ext_bus_pkg::access_cmd_t access_cmd = '0;
  logic [3:0] wait_ticks = 4'h0;
  logic [18:0] addr_seed = 19'h5A3C1;
  logic external_ready_in, access_done, busy, interface_timing_clock;
  logic external_bus_clock, read_strobe_n, write_strobe_n;
  logic zone_select_n, direction_line;
  logic [ext_bus_pkg::ADDR_W-1:0] external_address_bus;
  int miscompares = 0, n_tests = 0, zl = 0, rl = 0, wl = 0;
  int tl = 0;
  external_bus_access_timing uut (
    .clk, .rst_n, .timing_half_rate, .bus_half_rate, .zone_timing_config,
    .access_request, .access_cmd, .external_ready_in, .access_done, .busy,
    .interface_timing_clock, .external_bus_clock, .read_strobe_n,
    .write_strobe_n, .zone_select_n, .direction_line, .external_address_bus
  );
  ext_memory_model mem (.zone_select_n, .wait_ticks,
    .ready(external_ready_in));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    zl <= zl + int'(!zone_select_n);
    rl <= rl + int'(!read_strobe_n);
    wl <= wl + int'(!write_strobe_n);
    tl <= tl + int'(interface_timing_clock && !zone_select_n);
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic run(input logic wr, input int l, a, t,
    input logic pd, rdy_en, rdy_async);
    int z0, s0, o0, k, tk, m, base, t0;
    logic [18:0] ad;
    @(posedge clk);
    ad = addr_seed;
    addr_seed = addr_seed + 19'h2B6D7;
    tk = timing_half_rate ? 2 : 1;
    m = pd ? 2 : 1;
    base = (a * m + 1) * tk;
    zone_timing_config <= {l[1:0], a[2:0], t[1:0], l[1:0], a[2:0], t[1:0],
      pd, rdy_en, rdy_async};
    access_cmd <= {wr, ad};
    access_request <= 1'b1;
    z0 = zl;
    t0 = tl;
    s0 = wr ? wl : rl;
    o0 = wr ? rl : wl;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (access_done !== 1'b1 && k < 400);
    check("done", 1, access_done);
    access_request <= 1'b0;
    @(posedge clk);
    #1;
    check("address", ad, external_address_bus);
    check("other strobe", o0, wr ? rl : wl);
    check("busy", 0, busy);
    check("direction", 1, direction_line);
    if (rdy_en) begin
      check("stretch", 1, (wr ? wl : rl) - s0 > base + 4);
    end else begin
      check("strobe", base, (wr ? wl : rl) - s0);
      check("zone", base + (l + t) * m * tk, zl - z0);
      check("tclk", (base + (l + t) * m * tk) / tk, tl - t0);
    end
  endtask : run
  task automatic t_clock_modes;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      timing_half_rate <= i[1];
      bus_half_rate <= i[0];
      repeat (4) @(posedge clk);
      run(1'b1, 1, 1, 1, 1'b0, 1'b0, 1'b0);
      run(1'b0, 2, 3, 0, 1'b1, 1'b0, 1'b0);
    end
  endtask : t_clock_modes
  task automatic t_unchecked;
    run(1'b0, 0, 0, 0, 1'b0, 1'b0, 1'b0);
    run(1'b1, 3, 0, 3, 1'b1, 1'b0, 1'b0);
  endtask : t_unchecked
  task automatic t_ready;
    @(posedge clk);
    wait_ticks <= 4'h5;
    run(1'b1, 1, 2, 0, 1'b0, 1'b0, 1'b1);
    run(1'b0, 1, 2, 0, 1'b0, 1'b1, 1'b1);
    run(1'b1, 1, 1, 0, 1'b1, 1'b1, 1'b1);
    run(1'b0, 2, 1, 0, 1'b0, 1'b1, 1'b0);
  endtask : t_ready
  task automatic summarize;
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_clock_modes();
    t_unchecked();
    t_ready();
    summarize();
  end
  initial begin
    #3000000;
    miscompares++;
    summarize();
  end
endmodule : test_external_bus_access_timing
